// *** hdc_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module hdc_checker (
   // watched ports
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   input wire logic                 cs_n,
   input wire logic                 wr_n,
   input wire logic                 rd_n,
   input wire logic [15:0]          data_out,
   input wire logic                 data_oe,
   input wire hdc_pkg::hdc_dma_cfg_t dma_cfg,
   input wire logic [3:0]           burst_beats
);
   import hdc_pkg::*;
   logic [3:0] wr_age;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // cycles since the last write strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) wr_age <= 4'hF;
      else if (!wr_n) wr_age <= 4'h0;
      else if (wr_age != 4'hF) wr_age <= wr_age + 4'h1;
   end
   a_reset_clear: assert property ($rose(rst_n) |-> dma_cfg == HDC_DMA_RESET)
      else $error("dma config not clear after reset");
   a_cfg_cause: assert property ($changed(dma_cfg) |-> wr_age < 4'hA)
      else $error("dma config changed without a write");
   a_rsvd_zero: assert property (data_oe |-> data_out[15:8] == HDC_RSVD_HIGH)
      else $error("reserved read bits not zero");
   a_oe_cause: assert property ($rose(data_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2))
      else $error("bus driven without a read");
   a_burst_one: assert property ($stable(dma_cfg) && dma_cfg.burst_size == HDC_BURST_1
      |-> burst_beats == HDC_BEATS_1)
      else $error("single burst beats wrong");
   a_burst_four: assert property ($stable(dma_cfg) && dma_cfg.burst_size == HDC_BURST_4
      |-> burst_beats == HDC_BEATS_4)
      else $error("four burst beats wrong");
   a_burst_eight: assert property ($stable(dma_cfg) && dma_cfg.burst_size == HDC_BURST_8
      |-> burst_beats == HDC_BEATS_8)
      else $error("eight burst beats wrong");
   a_burst_rsvd: assert property ($stable(dma_cfg) && dma_cfg.burst_size == 2'h3
      |-> burst_beats == HDC_BEATS_1)
      else $error("reserved burst beats wrong");
   c_go: cover property (dma_cfg.dma_go);
   c_read: cover property ($rose(data_oe));
   c_eight: cover property (burst_beats == HDC_BEATS_8);
endmodule
`default_nettype wire

// *** hdc_dma_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hdc_dma_host (
   // senses and pins
   input  wire logic core_clk,
   input  wire logic req_hi,
   input  wire logic ack_hi,
   input  wire logic req_line_a,
   input  wire logic req_line_b,
   output var logic  ack_line_a,
   output var logic  ack_line_b
);
   // acknowledge one clock after a request is seen, A idles at the inverse of ack_hi, B idles high
   initial begin
      ack_line_a = 1'b1;
      ack_line_b = 1'b1;
      forever begin
         @(posedge core_clk);
         ack_line_a <= (req_line_a == req_hi) ? ack_hi : !ack_hi;
         ack_line_b <= req_line_b;
      end
   end
endmodule
`default_nettype wire

// *** hdc_pkg.sv ***
// What this block does
// - With single-channel routing clear, host DMA handshakes use pair A and peripheral ones pair B.
// - With single-channel routing set, both controllers share pair A and pair B stays idle.
// - Hardware config bit 6 picks the active level of ack input A, low after reset.
// - Hardware config bit 5 picks the active level of request output A, high after reset.
// - The bus-width field at bits 4 to 3 holds 01 for a 16-bit bus; other codes are reserved.
// - Hardware config bit 2 picks the active level of interrupt output A, low after reset.
// - Hardware config bit 1 picks level (0, reset) or pulse (1) signalling on interrupt A.
// - Bit 0 gates interrupt A; the pin asserts only with the gate set and a masked-in source.
// - Command 21h reads and A1h writes the DMA configuration register.
// - DMA config holds byte-count gating, burst size, go, buffer select and direction, all zero at reset.
// - Burst size 00 is single cycle, 01 four cycles, 10 eight cycles, 11 reserved.
// - With byte-count gating on, no host DMA request rises until a non-zero transfer count is loaded.
package hdc_pkg;
   localparam logic [7:0]  HDC_CMD_DMA_RD = 8'h21;
   localparam logic [7:0]  HDC_CMD_DMA_WR = 8'hA1;
   localparam logic [7:0]  HDC_CMD_HW_RD  = 8'h10;
   localparam logic [7:0]  HDC_CMD_HW_WR  = 8'h90;
   localparam logic [1:0]  HDC_WIDTH_16   = 2'h1;
   localparam logic [7:0]  HDC_HW_RESET   = 8'h28;
   localparam logic [7:0]  HDC_DMA_RESET  = 8'h00;
   localparam logic [7:0]  HDC_RSVD_HIGH  = 8'h00;
   localparam logic [1:0]  HDC_BURST_1    = 2'h0;
   localparam logic [1:0]  HDC_BURST_4    = 2'h1;
   localparam logic [1:0]  HDC_BURST_8    = 2'h2;
   localparam logic [3:0]  HDC_BEATS_1    = 4'h1;
   localparam logic [3:0]  HDC_BEATS_4    = 4'h4;
   localparam logic [3:0]  HDC_BEATS_8    = 4'h8;

   typedef struct packed {
      logic       single_channel_routing;
      logic       ack_in_sense;
      logic       req_out_sense;
      logic [1:0] host_bus_width;
      logic       irq_out_sense;
      logic       irq_signal_style;
      logic       irq_pin_gate;
   } hdc_hw_cfg_t;

   typedef struct packed {
      logic       byte_count_gating;
      logic [1:0] burst_size;
      logic       dma_go;
      logic [2:0] buffer_select;
      logic       transfer_direction;
   } hdc_dma_cfg_t;
endpackage

// *** hdc_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module hdc_regs (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // processor bus pins
   input  wire logic                  cs_n,
   input  wire logic                  wr_n,
   input  wire logic                  rd_n,
   input  wire logic                  cmd_sel,
   input  wire logic [15:0]           data_in,
   output logic      [15:0]           data_out,
   output logic                       data_oe,
   // internal controllers
   input  wire logic                  host_dma_want,
   input  wire logic                  periph_dma_want,
   input  wire logic                  count_nonzero,
   input  wire logic                  host_irq_pending,
   output logic                       host_ack,
   output logic                       periph_ack,
   // dma pins
   output logic                       req_line_a,
   output logic                       req_line_b,
   input  wire logic                  ack_line_a,
   input  wire logic                  ack_line_b,
   // interrupt pin
   output logic                       irq_line_a,
   // configuration to data mover
   output hdc_pkg::hdc_dma_cfg_t      dma_cfg,
   output logic      [3:0]            burst_beats
);
   import hdc_pkg::*;

   // configuration registers
   hdc_hw_cfg_t  hw_reg;
   hdc_hw_cfg_t  hw_next;
   hdc_dma_cfg_t dma_reg;
   hdc_dma_cfg_t dma_next;
   hdc_hw_cfg_t  hw_wdata;
   hdc_dma_cfg_t dma_wdata;
   logic [7:0]   cmd_reg;
   logic [7:0]   cmd_next;
   // pin synchronisers
   logic         cs_s1_reg;
   logic         cs_s2_reg;
   logic         cs_s3_reg;
   logic         wr_s1_reg;
   logic         wr_s2_reg;
   logic         wr_s3_reg;
   logic         rd_s1_reg;
   logic         rd_s2_reg;
   logic         cmdsel_s1_reg;
   logic         cmdsel_s2_reg;
   logic [15:0]  din_s1_reg;
   logic [15:0]  din_s2_reg;
   logic         ack_a_s1_reg;
   logic         ack_a_s2_reg;
   logic         ack_b_s1_reg;
   logic         ack_b_s2_reg;
   // write capture
   logic [15:0]  wdata_reg;
   logic [15:0]  wdata_next;
   logic         wphase_reg;
   logic         wphase_next;
   // output stage
   logic [15:0]  data_out_next;
   logic         data_oe_next;
   logic         req_a_next;
   logic         req_b_next;
   logic         host_ack_next;
   logic         periph_ack_next;
   logic         irq_next;
   logic         irq_act_reg;
   logic [3:0]   burst_beats_next;

   // bus strobes, active high after inversion
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_reg <= 1'h0;
         cs_s2_reg <= 1'h0;
         cs_s3_reg <= 1'h0;
      end else begin
         cs_s1_reg <= ~cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_s1_reg <= 1'h0;
         wr_s2_reg <= 1'h0;
         wr_s3_reg <= 1'h0;
      end else begin
         wr_s1_reg <= ~wr_n;
         wr_s2_reg <= wr_s1_reg;
         wr_s3_reg <= wr_s2_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_s1_reg <= 1'h0;
         rd_s2_reg <= 1'h0;
      end else begin
         rd_s1_reg <= ~rd_n;
         rd_s2_reg <= rd_s1_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdsel_s1_reg <= 1'h0;
         cmdsel_s2_reg <= 1'h0;
      end else begin
         cmdsel_s1_reg <= cmd_sel;
         cmdsel_s2_reg <= cmdsel_s1_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         din_s1_reg <= 16'h0000;
         din_s2_reg <= 16'h0000;
      end else begin
         din_s1_reg <= data_in;
         din_s2_reg <= din_s1_reg;
      end
   end

   // ack pins reset to their idle high level so no false ack follows reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_a_s1_reg <= 1'h1;
         ack_a_s2_reg <= 1'h1;
      end else begin
         ack_a_s1_reg <= ack_line_a;
         ack_a_s2_reg <= ack_a_s1_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_b_s1_reg <= 1'h1;
         ack_b_s2_reg <= 1'h1;
      end else begin
         ack_b_s1_reg <= ack_line_b;
         ack_b_s2_reg <= ack_b_s1_reg;
      end
   end

   // bus decode: a write is taken when the synchronised strobe goes away
   wire wr_active = cs_s2_reg & wr_s2_reg;
   wire wr_held   = cs_s3_reg & wr_s3_reg & wr_active;
   wire wr_end    = cs_s3_reg & wr_s3_reg & ~wr_active;
   wire cmd_write = wr_end & wphase_reg;
   wire dat_write = wr_end & ~wphase_reg;
   wire hw_sel    = cmd_reg == HDC_CMD_HW_WR;
   wire dma_sel   = cmd_reg == HDC_CMD_DMA_WR;
   wire hw_wr     = dat_write & hw_sel;
   wire dma_wr    = dat_write & dma_sel;
   wire hw_rd     = cmd_reg == HDC_CMD_HW_RD;
   wire dma_rd    = cmd_reg == HDC_CMD_DMA_RD;
   wire rd_active = cs_s2_reg & rd_s2_reg & ~cmdsel_s2_reg;
   wire rd_act    = rd_active & (hw_rd | dma_rd);
   wire [15:0] rd_data = hw_rd ? {HDC_RSVD_HIGH, hw_reg} : {HDC_RSVD_HIGH, dma_reg};

   // word and phase are captured while the strobe is steady and kept after, so the bus may change after it
   assign wdata_next  = wr_held ? din_s2_reg : wdata_reg;
   assign wphase_next = wr_held ? cmdsel_s2_reg : wphase_reg;
   assign hw_wdata    = hdc_hw_cfg_t'(wdata_reg[7:0]);
   assign dma_wdata   = hdc_dma_cfg_t'(wdata_reg[7:0]);
   assign cmd_next    = cmd_write ? wdata_reg[7:0] : cmd_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata_reg  <= 16'h0000;
         wphase_reg <= 1'h0;
      end else begin
         wdata_reg  <= wdata_next;
         wphase_reg <= wphase_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= 8'h00;
      end else begin
         cmd_reg <= cmd_next;
      end
   end

   // register next values
   always_comb begin
      hw_next  = hw_reg;
      dma_next = dma_reg;
      if (hw_wr) begin
         hw_next = hw_wdata;
         if (hw_wdata.host_bus_width != HDC_WIDTH_16) begin
            hw_next.host_bus_width = hw_reg.host_bus_width;
         end
      end
      if (dma_wr) begin
         dma_next = dma_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hw_reg  <= hdc_hw_cfg_t'(HDC_HW_RESET);
         dma_reg <= hdc_dma_cfg_t'(HDC_DMA_RESET);
      end else begin
         hw_reg  <= hw_next;
         dma_reg <= dma_next;
      end
   end

   // dma request routing and gating
   wire host_req_ok  = host_dma_want & dma_reg.dma_go
                     & (~dma_reg.byte_count_gating | count_nonzero);
   wire ack_a_act    = ack_a_s2_reg ~^ hw_reg.ack_in_sense;
   wire ack_b_act    = ~ack_b_s2_reg;
   wire req_a_act    = hw_reg.single_channel_routing
                     ? (host_req_ok | periph_dma_want) : host_req_ok;
   wire req_b_act    = ~hw_reg.single_channel_routing & periph_dma_want;
   wire host_ack_hit = ack_a_act & host_req_ok;
   wire per_ack_hit  = hw_reg.single_channel_routing
                     ? (ack_a_act & ~host_req_ok & periph_dma_want) : ack_b_act;
   assign req_a_next      = req_a_act ~^ hw_reg.req_out_sense;
   assign req_b_next      = ~req_b_act;
   assign host_ack_next   = host_ack_hit;
   assign periph_ack_next = per_ack_hit;

   // interrupt shaping: pulse style gives one clock per rising gated event
   wire irq_act   = hw_reg.irq_pin_gate & host_irq_pending;
   wire irq_shape = hw_reg.irq_signal_style ? (irq_act & ~irq_act_reg) : irq_act;
   assign irq_next = irq_shape ~^ hw_reg.irq_out_sense;

   // burst size to beat count, reserved code gives one beat
   always_comb begin
      unique case (dma_reg.burst_size)
         HDC_BURST_4: burst_beats_next = HDC_BEATS_4;
         HDC_BURST_8: burst_beats_next = HDC_BEATS_8;
         default:     burst_beats_next = HDC_BEATS_1;
      endcase
   end

   assign data_out_next = rd_data;
   assign data_oe_next  = rd_act;

   // output flip-flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= 16'h0000;
      end else begin
         data_out <= data_out_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_oe <= 1'h0;
      end else begin
         data_oe <= data_oe_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_line_a <= 1'h0;
      end else begin
         req_line_a <= req_a_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_line_b <= 1'h1;
      end else begin
         req_line_b <= req_b_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_ack <= 1'h0;
      end else begin
         host_ack <= host_ack_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_ack <= 1'h0;
      end else begin
         periph_ack <= periph_ack_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_line_a  <= 1'h1;
         irq_act_reg <= 1'h0;
      end else begin
         irq_line_a  <= irq_next;
         irq_act_reg <= irq_act;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_cfg <= hdc_dma_cfg_t'(HDC_DMA_RESET);
      end else begin
         dma_cfg <= dma_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_beats <= HDC_BEATS_1;
      end else begin
         burst_beats <= burst_beats_next;
      end
   end
endmodule
`default_nettype wire

// *** test_hdc_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_hdc_regs;
   import hdc_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, cmd_sel = 1'b0;
   logic hw = 1'b0, pw = 1'b0, cnz = 1'b0, pend = 1'b0, req_hi = 1'b1, ack_hi = 1'b0;
   logic [15:0] data_in = 16'h0000, data_out, q;
   logic data_oe, host_ack, periph_ack, ra, rb, aa, ab, irq;
   hdc_dma_cfg_t dma_cfg;
   logic [3:0] beats;
   logic [1:0] bc [3] = '{HDC_BURST_1, HDC_BURST_4, HDC_BURST_8};
   logic [3:0] bt [3] = '{HDC_BEATS_1, HDC_BEATS_4, HDC_BEATS_8};
   int n_fail = 0, checked = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   hdc_regs dut (.core_clk, .rst_n, .cs_n, .wr_n, .rd_n, .cmd_sel, .data_in, .data_out,
      .data_oe, .host_dma_want(hw), .periph_dma_want(pw), .count_nonzero(cnz),
      .host_irq_pending(pend), .host_ack, .periph_ack, .req_line_a(ra), .req_line_b(rb),
      .ack_line_a(aa), .ack_line_b(ab), .irq_line_a(irq), .dma_cfg, .burst_beats(beats));
   hdc_dma_host host (.core_clk, .req_hi, .ack_hi, .req_line_a(ra), .req_line_b(rb),
      .ack_line_a(aa), .ack_line_b(ab));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic rd, input logic cmd, input logic [15:0] d);
      @(posedge core_clk);
      {cs_n, rd_n, wr_n, cmd_sel, data_in} <= {1'b0, !rd, rd, cmd, d};
      repeat (5) @(posedge core_clk);
      q = data_out;
      if (rd) chk({15'h0000, data_oe}, 16'h0001);
      {cs_n, rd_n, wr_n} <= 3'h7;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      acc(1'b0, 1'b1, {8'h00, c});
      acc(1'b0, 1'b0, d);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      acc(1'b0, 1'b1, {8'h00, c});
      acc(1'b1, 1'b0, 16'h0000);
      chk(q, exp);
   endtask
   task automatic pins(input logic [3:0] exp);
      repeat (8) @(posedge core_clk);
      chk({12'h000, ra, rb, host_ack, periph_ack}, {12'h000, exp});
   endtask
   task automatic finish_test;
      if (n_fail == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(HDC_CMD_DMA_RD, 16'h0000);
      rd(HDC_CMD_HW_RD, 16'h0028);
      wr(HDC_CMD_DMA_WR, 16'hFFFF);
      rd(HDC_CMD_DMA_RD, 16'h00FF);
      for (int b = 0; b < 3; b++) begin
         wr(HDC_CMD_DMA_WR, {9'h000, bc[b], 5'h00});
         chk({12'h000, beats}, {12'h000, bt[b]});
      end
      wr(HDC_CMD_HW_WR, 16'h0020);
      rd(HDC_CMD_HW_RD, 16'h0028);
      wr(HDC_CMD_DMA_WR, 16'h0010);
      chk({8'h00, dma_cfg}, 16'h0010);
      {hw, pw} <= 2'h3;
      pins(4'hB);
      hw <= 1'b0;
      wr(HDC_CMD_HW_WR, 16'h00A8);
      pins(4'hD);
      {hw, pw, req_hi, ack_hi} <= 4'h9;
      wr(HDC_CMD_HW_WR, 16'h0048);
      pins(4'h6);
      wr(HDC_CMD_DMA_WR, 16'h0090);
      pins(4'hC);
      cnz <= 1'b1;
      pins(4'h6);
      {req_hi, ack_hi, pend} <= 3'h5;
      wr(HDC_CMD_HW_WR, 16'h0028);
      chk({15'h0000, irq}, 16'h0001);
      wr(HDC_CMD_HW_WR, 16'h0029);
      chk({15'h0000, irq}, 16'h0000);
      wr(HDC_CMD_HW_WR, 16'h002D);
      chk({15'h0000, irq}, 16'h0001);
      wr(HDC_CMD_HW_WR, 16'h002F);
      pend <= 1'b0;
      repeat (4) @(posedge core_clk);
      pend <= 1'b1;
      @(negedge core_clk);
      chk({15'h0000, irq}, 16'h0000);
      @(negedge core_clk);
      chk({15'h0000, irq}, 16'h0001);
      @(negedge core_clk);
      chk({15'h0000, irq}, 16'h0000);
      repeat (8) @(posedge core_clk);
      chk({15'h0000, irq}, 16'h0000);
      finish_test();
   end
endmodule
bind hdc_regs hdc_checker u_chk (.core_clk, .rst_n, .cs_n, .wr_n, .rd_n, .data_out, .data_oe,
   .dma_cfg, .burst_beats);
`default_nettype wire
